// ===== src/ssc_config_regs.sv
`timescale 1ns/1ps
`default_nettype none

`include "ssc_regs.svh"

module ssc_config_regs (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        serial_clk_i,
    input  wire logic        serial_in_i,
    input  wire logic        latch_strobe_i,
    input  wire logic        if_ndiv_i,
    input  wire logic        if_rdiv_i,
    input  wire logic        rf_ndiv_i,
    input  wire logic        rf_rdiv_i,
    input  wire logic        if_lock_i,
    input  wire logic        rf_lock_i,
    output logic [1:0]       if_pump_current_o,
    output logic [10:0]      if_pump_ua_o,
    output logic [2:0]       monitor_select_o,
    output logic             mux_monitor_out_o,
    output logic [12:0]      if_ref_divider_o,
    output logic [1:0]       frac_mode_o,
    output logic             dither_enable_o,
    output logic             frac_mode_valid_o,
    output logic             rf_pd_polarity_o,
    output logic [1:0]       rf_pump_current_o,
    output logic [10:0]      rf_pump_ua_o,
    output logic             prescaler_select_o,
    output logic [2:0]       rf_ref_divider_o,
    output logic [12:0]      modulo_extender_o,
    output logic             if_pd_polarity_o,
    output logic [1:0]       power_mode_o,
    output logic             rf_enable_o,
    output logic             if_enable_o,
    output logic [16:0]      if_main_divider_o,
    output logic [7:0]       fraction_word_o,
    output logic [11:0]      rf_main_divider_o,
    output ssc_pkg::ssc_ratio_t rf_total_ratio_o
);
    import ssc_pkg::*;

    ssc_link_if lnk ();

    // serial shifting lives entirely on the link clock
    ssc_shift_link u_shift (
        .serial_clk_i (serial_clk_i),
        .rst_n_i      (rst_n_i),
        .serial_in_i  (serial_in_i),
        .lnk          (lnk.link)
    );

    // pump current in ua (if steps of 400, rf steps of 120)
    function automatic logic [10:0] pump_ua(
        input logic [1:0]  code,
        input logic [10:0] step
    );
        return step * ({9'h000, code} + 11'h001);
    endfunction

    logic       latch_meta_r;
    logic       latch_sync_r;
    logic       latch_prev_r;
    logic       sclk_meta_r;
    logic       sclk_sync_r;
    logic [5:0] mon_meta_r;
    logic [5:0] mon_sync_r;
    logic       take;
    ssc_addr_t  take_addr;
    ssc_word_t  word_r [`SSC_WORD_COUNT];
    logic       frac_written_r;
    logic       mon_r;
    logic [10:0] if_ua_r;
    logic [10:0] rf_ua_r;
    logic       rf_en_r;
    logic       if_en_r;
    logic       dither_r;
    logic [11:0] n1_eff;
    ssc_ratio_t ratio_r;

    // strobe and serial clock level cross by two flip-flops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // high: a strobe left high at release gives no false rise
            latch_meta_r <= 1'b1;
            latch_sync_r <= 1'b1;
            latch_prev_r <= 1'b1;
            sclk_meta_r  <= 1'b0;
            sclk_sync_r  <= 1'b0;
        end else begin
            latch_meta_r <= latch_strobe_i;
            latch_sync_r <= latch_meta_r;
            latch_prev_r <= latch_sync_r;
            sclk_meta_r  <= serial_clk_i;
            sclk_sync_r  <= sclk_meta_r;
        end
    end

    // monitor sources come from analog dividers, asynchronous to us
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mon_meta_r <= 6'h00;
            mon_sync_r <= 6'h00;
        end else begin
            mon_meta_r <= {rf_lock_i, if_lock_i, rf_rdiv_i,
                           rf_ndiv_i, if_rdiv_i, if_ndiv_i};
            mon_sync_r <= mon_meta_r;
        end
    end

    // transfer only on a strobe rise seen with the serial clock low;
    // the word is quasi-static then because the host stops clocking
    assign take = latch_sync_r & ~latch_prev_r & ~sclk_sync_r;
    assign take_addr = lnk.word[`SSC_ADDR_MSB:0];

    // one holding word per address
    generate
        for (genvar g = 0; g < `SSC_WORD_COUNT; g++) begin : g_word
            always_ff @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    word_r[g] <= `SSC_WORD_RST;
                end else if (take && take_addr == 2'(g)) begin
                    word_r[g] <= lnk.word;
                end
            end
        end
    endgenerate

    // dither bits stay untrusted until word 00 is written once
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frac_written_r <= 1'b0;
        end else if (take && take_addr == `SSC_ADDR_IF_REF) begin
            frac_written_r <= 1'b1;
        end
    end

    // word 00 fields
    assign if_pump_current_o =
        word_r[0][`SSC_IF_PUMP_MSB:`SSC_IF_PUMP_LSB];
    assign monitor_select_o =
        word_r[0][`SSC_MON_SEL_MSB:`SSC_MON_SEL_LSB];
    assign if_ref_divider_o =
        word_r[0][`SSC_IF_REF_MSB:`SSC_IF_REF_LSB];
    assign frac_mode_o =
        word_r[0][`SSC_FRAC_MODE_MSB:`SSC_FRAC_MODE_LSB];
    assign frac_mode_valid_o = frac_written_r;

    // word 01 fields
    assign rf_pd_polarity_o  = word_r[1][`SSC_RF_POL_BIT];
    assign rf_pump_current_o =
        word_r[1][`SSC_RF_PUMP_MSB:`SSC_RF_PUMP_LSB];
    assign prescaler_select_o = word_r[1][`SSC_PRESCALE_BIT];
    assign rf_ref_divider_o =
        word_r[1][`SSC_RF_REF_MSB:`SSC_RF_REF_LSB];
    assign modulo_extender_o =
        word_r[1][`SSC_MOD_EXT_MSB:`SSC_MOD_EXT_LSB];

    // word 10 fields
    assign if_pd_polarity_o = word_r[2][`SSC_IF_POL_BIT];
    assign power_mode_o =
        word_r[2][`SSC_POWER_MSB:`SSC_POWER_LSB];
    assign if_main_divider_o =
        word_r[2][`SSC_IF_MAIN_MSB:`SSC_IF_MAIN_LSB];

    // word 11 fields
    assign fraction_word_o =
        word_r[3][`SSC_FRAC_MSB:`SSC_FRAC_LSB];
    assign rf_main_divider_o =
        word_r[3][`SSC_RF_MAIN_MSB:`SSC_RF_MAIN_LSB];

    // decoded pump currents, one cycle behind the field
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            if_ua_r <= `SSC_IF_PUMP_STEP;
            rf_ua_r <= `SSC_RF_PUMP_STEP;
        end else begin
            if_ua_r <= pump_ua(if_pump_current_o,
                               `SSC_IF_PUMP_STEP);
            rf_ua_r <= pump_ua(rf_pump_current_o,
                               `SSC_RF_PUMP_STEP);
        end
    end
    assign if_pump_ua_o = if_ua_r;
    assign rf_pump_ua_o = rf_ua_r;

    // enables: reset state is both on, before any word arrives
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rf_en_r <= 1'b1;
            if_en_r <= 1'b1;
        end else begin
            rf_en_r <= (power_mode_o == `SSC_POWER_BOTH) ||
                       (power_mode_o == `SSC_POWER_RF_ONLY);
            if_en_r <= (power_mode_o == `SSC_POWER_BOTH) ||
                       (power_mode_o == `SSC_POWER_IF_ONLY);
        end
    end
    assign rf_enable_o = rf_en_r;
    assign if_enable_o = if_en_r;

    // reserved codes leave dithering off rather than guess
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dither_r <= 1'b0;
        end else begin
            dither_r <= frac_mode_o == `SSC_FRAC_DITHER;
        end
    end
    assign dither_enable_o = dither_r;

    // with the small prescaler only eleven divider bits count
    assign n1_eff = prescaler_select_o ? rf_main_divider_o
                  : {1'b0, rf_main_divider_o[10:0]};

    // ratio in units of 2^-21: n1 + 3.5 + fn/256 + me/2^21
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ratio_r <= `SSC_RATIO_OFFSET;
        end else begin
            ratio_r <= {1'b0, n1_eff, 21'h000000}
                     + `SSC_RATIO_OFFSET
                     + {13'h0000, fraction_word_o, 13'h0000}
                     + {21'h000000, modulo_extender_o};
        end
    end
    assign rf_total_ratio_o = ratio_r;

    // monitor pin; lock sources are high when locked
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mon_r <= 1'b0;
        end else begin
            unique case (monitor_select_o)
                `SSC_MON_IF_NDIV:  mon_r <= mon_sync_r[0];
                `SSC_MON_IF_RDIV:  mon_r <= mon_sync_r[1];
                `SSC_MON_RF_NDIV:  mon_r <= mon_sync_r[2];
                `SSC_MON_RF_RDIV:  mon_r <= mon_sync_r[3];
                `SSC_MON_IF_LOCK:  mon_r <= mon_sync_r[4];
                `SSC_MON_RF_LOCK:  mon_r <= mon_sync_r[5];
                `SSC_MON_ALL_LOCK: mon_r <= &mon_sync_r[5:4];
                `SSC_MON_LOW:      mon_r <= 1'b0;
            endcase
        end
    end
    assign mux_monitor_out_o = mon_r;

    // checks, all in the core clock domain
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    addr_decode_a: assert property (
        take |=> word_r[$past(take_addr)] == $past(lnk.word))
        else $error("word not stored at its address");

    high_refused_a: assert property (
        (latch_sync_r && !latch_prev_r && sclk_sync_r)
        |=> $stable(word_r[0]) && $stable(word_r[1])
            && $stable(word_r[2]) && $stable(word_r[3]))
        else $error("word taken while serial clock high");

    if_pump_a: assert property (
        take && take_addr == `SSC_ADDR_IF_REF
        |-> ##2 if_pump_ua_o == 11'(400 *
            ($past(lnk.word[3:2], 2) + 1)))
        else $error("if pump current wrong");

    rf_pump_a: assert property (
        take && take_addr == `SSC_ADDR_RF_REF
        |-> ##2 rf_pump_ua_o == 11'(120 *
            ($past(lnk.word[4:3], 2) + 1)))
        else $error("rf pump current wrong");

    power_mode_a: assert property (
        take && take_addr == `SSC_ADDR_IF_MAIN
        && lnk.word[4:3] == `SSC_POWER_DOWN
        |-> ##2 !rf_enable_o && !if_enable_o)
        else $error("power down not applied");

    dither_mode_a: assert property (
        take && take_addr == `SSC_ADDR_IF_REF
        |-> ##2 dither_enable_o == ($past(lnk.word[21:20], 2)
            == `SSC_FRAC_DITHER) && frac_mode_valid_o)
        else $error("dither mode not decoded");

    total_ratio_a: assert property (
        take && take_addr == `SSC_ADDR_RF_MAIN
        && prescaler_select_o && $stable(word_r[1])
        |-> ##2 rf_total_ratio_o
            == {1'b0, $past(lnk.word[21:10], 2), 21'h000000}
               + `SSC_RATIO_OFFSET
               + {13'h0000, $past(lnk.word[9:2], 2), 13'h0000}
               + {21'h000000, modulo_extender_o})
        else $error("total ratio wrong");

    lock_monitor_a: assert property (
        monitor_select_o == `SSC_MON_IF_LOCK
        && $stable(monitor_select_o)
        |-> mux_monitor_out_o == $past(mon_sync_r[4]))
        else $error("lock monitor level wrong");

    enabled_up_a: assert property (
        power_mode_o == `SSC_POWER_BOTH
        && $stable(power_mode_o)
        |-> rf_enable_o && if_enable_o)
        else $error("synthesizers not enabled");

    rf_only_a: assert property (
        take && take_addr == `SSC_ADDR_IF_MAIN
        && lnk.word[4:3] == `SSC_POWER_RF_ONLY
        |-> ##2 rf_enable_o && !if_enable_o)
        else $error("rf only mode not applied");

    valid_sticky_a: assert property (
        frac_mode_valid_o |=> frac_mode_valid_o)
        else $error("dither mode valid flag dropped");

    take_word0_c: cover property (
        take && take_addr == `SSC_ADDR_IF_REF);
    take_word3_c: cover property (
        take && take_addr == `SSC_ADDR_RF_MAIN);
    refused_high_c: cover property (
        latch_sync_r && !latch_prev_r && sclk_sync_r);
    power_down_c: cover property (!rf_enable_o && !if_enable_o);
    lock_both_c: cover property (
        monitor_select_o == `SSC_MON_ALL_LOCK && mux_monitor_out_o);

endmodule // ssc_config_regs

`default_nettype wire

// ===== src/ssc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ssc_link_if;
    import ssc_pkg::*;
    ssc_word_t word;
    modport link (output word);
    modport core (input word);
endinterface

`default_nettype wire

// ===== src/ssc_pkg.sv
`include "ssc_regs.svh"

package ssc_pkg;
    typedef logic [`SSC_WORD_W-1:0] ssc_word_t;
    typedef logic [1:0]             ssc_addr_t;
    typedef logic [33:0]            ssc_ratio_t;
endpackage

// ===== src/ssc_regs.svh
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// serial word geometry
`define SSC_WORD_W        22
`define SSC_ADDR_MSB      1
`define SSC_WORD_COUNT    4

// word addresses carried in the two low bits
`define SSC_ADDR_IF_REF   2'h0
`define SSC_ADDR_RF_REF   2'h1
`define SSC_ADDR_IF_MAIN  2'h2
`define SSC_ADDR_RF_MAIN  2'h3

// word 00 fields
`define SSC_IF_PUMP_LSB   2
`define SSC_IF_PUMP_MSB   3
`define SSC_MON_SEL_LSB   4
`define SSC_MON_SEL_MSB   6
`define SSC_IF_REF_LSB    7
`define SSC_IF_REF_MSB    19
`define SSC_FRAC_MODE_LSB 20
`define SSC_FRAC_MODE_MSB 21

// word 01 fields
`define SSC_RF_POL_BIT    2
`define SSC_RF_PUMP_LSB   3
`define SSC_RF_PUMP_MSB   4
`define SSC_PRESCALE_BIT  5
`define SSC_RF_REF_LSB    6
`define SSC_RF_REF_MSB    8
`define SSC_MOD_EXT_LSB   9
`define SSC_MOD_EXT_MSB   21

// word 10 fields
`define SSC_IF_POL_BIT    2
`define SSC_POWER_LSB     3
`define SSC_POWER_MSB     4
`define SSC_IF_MAIN_LSB   5
`define SSC_IF_MAIN_MSB   21

// word 11 fields
`define SSC_FRAC_LSB      2
`define SSC_FRAC_MSB      9
`define SSC_RF_MAIN_LSB   10
`define SSC_RF_MAIN_MSB   21

// reset values: all zero keeps both synthesizers enabled
`define SSC_WORD_RST      22'h000000

// field codes
`define SSC_FRAC_DITHER   2'h2
`define SSC_FRAC_NODITHER 2'h3
`define SSC_POWER_BOTH    2'h0
`define SSC_POWER_RF_ONLY 2'h1
`define SSC_POWER_IF_ONLY 2'h2
`define SSC_POWER_DOWN    2'h3

// monitor multiplexer codes
`define SSC_MON_IF_NDIV   3'h0
`define SSC_MON_IF_RDIV   3'h1
`define SSC_MON_IF_LOCK   3'h2
`define SSC_MON_RF_NDIV   3'h3
`define SSC_MON_RF_RDIV   3'h4
`define SSC_MON_RF_LOCK   3'h5
`define SSC_MON_ALL_LOCK  3'h6
`define SSC_MON_LOW       3'h7

// charge pump current steps and ratio offset (3.5 in 2^-21 units)
`define SSC_IF_PUMP_STEP  11'h190
`define SSC_RF_PUMP_STEP  11'h078
`define SSC_RATIO_OFFSET  34'h000700000

`endif

// ===== src/ssc_shift_link.sv
`timescale 1ns/1ps
`default_nettype none

`include "ssc_regs.svh"

module ssc_shift_link (
    input  wire logic  serial_clk_i,
    input  wire logic  rst_n_i,
    input  wire logic  serial_in_i,
    ssc_link_if.link   lnk
);
    import ssc_pkg::*;

    ssc_word_t shift_r;
    logic [1:0] edges_r;

    // edges seen since reset, saturating; the order check needs two
    // fresh bits, since the clock is idle while reset is held
    always_ff @(posedge serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            edges_r <= 2'h0;
        end else if (edges_r != 2'h2) begin
            edges_r <= edges_r + 2'h1;
        end
    end

    // msb arrives first, so it ends up at the top after 22 edges
    always_ff @(posedge serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_r <= `SSC_WORD_RST;
        end else begin
            shift_r <= {shift_r[`SSC_WORD_W-2:0], serial_in_i};
        end
    end

    // held static by the host while the strobe is high
    assign lnk.word = shift_r;

    shift_in_a: assert property (@(posedge serial_clk_i)
        disable iff (!rst_n_i)
        edges_r == 2'h2 |-> lnk.word[1] == $past(serial_in_i, 2))
        else $error("serial bit not shifted in order");

endmodule // ssc_shift_link

`default_nettype wire

// ===== verification/ssc_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ssc_config_regs_tb;
    import ssc_pkg::*;

    logic        clock_i;
    logic        rst_n_i;
    wire logic   serial_clk_i;
    wire logic   serial_in_i;
    wire logic   latch_strobe_i;
    logic [5:0]  src;
    logic [1:0]  if_pump_current_o, frac_mode_o;
    logic [1:0]  rf_pump_current_o, power_mode_o;
    logic [10:0] if_pump_ua_o, rf_pump_ua_o;
    logic [2:0]  monitor_select_o, rf_ref_divider_o;
    logic [12:0] if_ref_divider_o, modulo_extender_o;
    logic [16:0] if_main_divider_o;
    logic [7:0]  fraction_word_o;
    logic [11:0] rf_main_divider_o;
    ssc_ratio_t  rf_total_ratio_o;
    logic        mux_monitor_out_o, dither_enable_o, frac_mode_valid_o;
    logic        rf_pd_polarity_o, prescaler_select_o, if_pd_polarity_o;
    logic        rf_enable_o, if_enable_o;
    int          err_total, cmp_count, cyc;
    ssc_word_t   sh[4], hw[4], q[$];
    logic        v0;
    logic [31:0] seed;

    // field outputs in word bit order [21:2], one 20-bit slice per address
    wire logic [79:0] vec = {rf_main_divider_o, fraction_word_o,
        if_main_divider_o, power_mode_o, if_pd_polarity_o,
        modulo_extender_o, rf_ref_divider_o, prescaler_select_o,
        rf_pump_current_o, rf_pd_polarity_o, frac_mode_o,
        if_ref_divider_o, monitor_select_o, if_pump_current_o};

    ssc_config_regs i_ssc_config_regs (
        .clock_i, .rst_n_i, .serial_clk_i, .serial_in_i, .latch_strobe_i,
        .if_ndiv_i(src[0]), .if_rdiv_i(src[1]), .if_lock_i(src[2]),
        .rf_ndiv_i(src[3]), .rf_rdiv_i(src[4]), .rf_lock_i(src[5]),
        .if_pump_current_o, .if_pump_ua_o, .monitor_select_o,
        .mux_monitor_out_o, .if_ref_divider_o, .frac_mode_o,
        .dither_enable_o, .frac_mode_valid_o, .rf_pd_polarity_o,
        .rf_pump_current_o, .rf_pump_ua_o, .prescaler_select_o,
        .rf_ref_divider_o, .modulo_extender_o, .if_pd_polarity_o,
        .power_mode_o, .rf_enable_o, .if_enable_o, .if_main_divider_o,
        .fraction_word_o, .rf_main_divider_o, .rf_total_ratio_o
    );

    ssc_host_model i_ssc_host_model (
        .serial_clk_o   (serial_clk_i),
        .serial_in_o    (serial_in_i),
        .latch_strobe_o (latch_strobe_i)
    );

    // 20 MHz core clock
    initial clock_i = 1'b0;
    always #25 clock_i = ~clock_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string n, input logic [33:0] e,
                       input logic [33:0] g);
        cmp_count++;
        if (e !== g) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // every output but the monitor pin worked out from the shadow words and v0
    task automatic check_all;
        logic [11:0] n1;
        logic [33:0] r;
        // the 8/9 prescaler uses only 11 bits of the main divider
        n1 = sh[1][5] ? sh[3][21:10] : {1'b0, sh[3][20:10]};
        r = {n1, 21'h0} + 34'h700000 + {sh[3][9:2], 13'h0} + sh[1][21:9];
        for (int a = 0; a < 4; a++)
            chk($sformatf("word%0d", a), sh[a][21:2], vec[a*20 +: 20]);
        chk("if_ua", 34'h190 * (sh[0][3:2] + 34'h1), if_pump_ua_o);
        chk("rf_ua", 34'h78 * (sh[1][4:3] + 34'h1), rf_pump_ua_o);
        chk("enables", {~sh[2][4], ~sh[2][3]}, {rf_enable_o, if_enable_o});
        chk("dither", {sh[0][21:20] == 2'h2, v0},
            {dither_enable_o, frac_mode_valid_o});
        chk("ratio", r, rf_total_ratio_o);
    endtask

    task automatic do_reset;
        rst_n_i = 1'b0;
        repeat (4) @(posedge clock_i);
        #2 rst_n_i = 1'b1;
        for (int a = 0; a < 4; a++) begin
            sh[a] = '0;
            hw[a] = '0;
        end
        v0 = 1'b0;
        q.delete();
        repeat (2) @(posedge clock_i);
        #1 check_all;
    endtask

    // a word equal to the held one would show nothing, so bit 10 flips
    task automatic wr(input logic [31:0] v, input int n, input bit bad);
        if (!bad) begin
            if (v[21:0] == hw[v[1:0]])
                v[10] = ~v[10];
            hw[v[1:0]] = v[21:0];
            q.push_back(v[21:0]);
        end
        i_ssc_host_model.send(v, n, bad);
        for (int k = 0; k < 40 && q.size() > 0; k++)
            @(posedge clock_i);
        if (q.size() > 0)
            chk("word_taken", 34'h0, q.size());
        repeat (4) @(posedge clock_i);
        #2;
    endtask

    // watcher: a change of the field outputs retires the oldest note
    initial begin
        logic [79:0] prev;
        ssc_word_t   w;
        prev = '0;
        forever begin
            @(posedge clock_i);
            #1;
            if (rst_n_i === 1'b1 && vec !== prev) begin
                if (q.size() == 0) begin
                    chk("spurious_update", 34'h0, 34'h1);
                end else begin
                    w = q.pop_front();
                    sh[w[1:0]] = w;
                    if (w[1:0] == 2'h0)
                        v0 = 1'b1;
                    repeat (2) @(posedge clock_i);
                    #1 check_all;
                end
            end
            prev = vec;
        end
    end

    // hang guard, far above the expected run length
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            $display("CHECK FAILED timeout expected done seen hang");
            stop_test;
        end
    end

    initial begin
        logic [31:0] v;
        seed = 32'h00000029;
        src = 6'h00;
        do_reset;
        $display("test reset done");
        // first write sets the dither mode, then each monitor source
        for (int c = 0; c < 8; c++) begin
            seed = lfsr(seed);
            wr({seed[31:22], 2'h2, seed[19:7], 3'(c), seed[3:2], 2'h0},
               22, 1'b0);
            repeat (4) begin
                @(posedge clock_i);
                #2 src = seed[5:0];
                seed = lfsr(seed);
                repeat (4) @(posedge clock_i);
                #1 chk("monitor", c < 6 ? src[c] : (c == 6 ?
                    src[2] & src[5] : 1'b0), mux_monitor_out_o);
            end
        end
        $display("test monitor done");
        // every two-bit code at every address
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            v = seed;
            v[1:0] = i[1:0];
            if (i[1:0] == 2'h0)
                v[3:2] = i[3:2];
            else
                v[4:3] = i[3:2];
            v[21:20] = i[3:2];
            wr(v, 22, 1'b0);
        end
        $display("test codes done");
        // both prescalers; bit 11 of the main divider set for the 8/9 case
        wr({10'h0, 13'hccc, 3'h3, 1'h1, 2'h3, 1'h1, 2'h1}, 22, 1'b0);
        wr({10'h0, 12'h12d, 8'h86, 2'h3}, 22, 1'b0);
        wr({10'h0, 12'h868, 8'h31, 2'h3}, 22, 1'b0);
        wr({10'h0, 13'h762, 3'h1, 1'h0, 2'h0, 1'h0, 2'h1}, 22, 1'b0);
        $display("test ratio done");
        // strobe rising with the clock high must be ignored
        seed = lfsr(seed);
        wr(seed, 22, 1'b1);
        seed = lfsr(seed);
        wr(seed, 22, 1'b0);
        // extra leading bits are pushed out of the shift register
        seed = lfsr(seed);
        wr(seed, 26, 1'b0);
        $display("test link done");
        @(posedge clock_i);
        #2 do_reset;
        wr(seed ^ 32'h00155555, 22, 1'b0);
        $display("test second reset done");
        stop_test;
    end
endmodule // ssc_config_regs_tb

`default_nettype wire

// ===== verification/ssc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host end of the three-wire link; its clock runs only inside frames
module ssc_host_model (
    output var logic serial_clk_o,
    output var logic serial_in_o,
    output var logic latch_strobe_o
);
    // idle link: clock low, strobe low
    initial begin
        serial_clk_o   = 1'b0;
        serial_in_o    = 1'b0;
        latch_strobe_o = 1'b0;
    end

    // n bits msb first at 12 ns a bit, then a strobe pulse;
    // bad raises the strobe while the clock is high
    task automatic send(input logic [31:0] v, input int n, input bit bad);
        latch_strobe_o = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_o = v[i];
            #6 serial_clk_o = 1'b1;
            #6 serial_clk_o = 1'b0;
        end
        // released data line shows the inverse, never a stale copy
        serial_in_o = ~v[0];
        if (bad) begin
            serial_clk_o = 1'b1;
        end
        #200 latch_strobe_o = 1'b1;
        // strobe drops before the clock so no edge lands while it is high
        #300 latch_strobe_o = 1'b0;
        #20 serial_clk_o = 1'b0;
    endtask
endmodule // ssc_host_model

`default_nettype wire
